/* design/ccd_decoder.sv */
// card command decoder: header parse, data phases, status and get-response
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01: record update is a0 dc; p2 02 next, 03 previous, 04 absolute/current.
// RULE_02: in next or previous mode the received p1 is ignored.
// RULE_03: seek is a2 with p1 00; p2 low nibble 0..3 picks direction.
// RULE_04: seek p2 high nibble 0 is type 1, 1 is type 2.
// RULE_05: type 1 seek has no response; type 2 gives one record byte.
// RULE_06: increase is 32, p3 03; response is record then the addend.
// RULE_07: verify 20 p3 08, change 24 p3 10; p2 01/02 picks secret.
// RULE_08: disable 26 and enable 28 use p2 01 and p3 08.
// RULE_09: unblock 2c p3 10; p2 00 first secret, 02 second.
// RULE_10: invalidate 04 and rehabilitate 44 have all-zero parameters, no data.
// RULE_11: authentication 88 p3 10; response four plus eight bytes, msb first.
// RULE_12: sleep fa with zero parameters and no data.
// RULE_13: get-response c0 serves data only after responding commands.
// RULE_14: get-response not directly after its command answers 6f 00.
// RULE_15: get-response is accepted as first command after activation.
// RULE_16: bit b8 is the msb of every byte.
// RULE_17: reserved bytes and bits are driven as zero.
// RULE_18: holder secret is eight digit bytes padded with ff by terminal.
// RULE_19: unlock secret always holds exactly eight digits.
// RULE_20: access conditions are 4-bit codes in three bytes.
// RULE_21: shared codes used as admin levels report that level's code.
// RULE_22: normal end is 90 00; pending data is 9f with length.
// RULE_23: technical problem without diagnosis is 6f 00.
// RULE_24: unknown instruction gives 6d 00, wrong class gives 6e 00.
// RULE_25: full header first, then exactly p3 data bytes, then status.
module ccd_decoder #(
   parameter int RESP_DEPTH = 16,
   parameter int CAP_DEPTH  = 16
) (
   input  wire logic              clock_in,
   input  wire logic              resetn_in,
   input  wire logic [7:0]        avs_address_in,
   input  wire logic              avs_read_in,
   input  wire logic              avs_write_in,
   input  wire logic [31:0]       avs_writedata_in,
   input  wire logic [3:0]        avs_byteenable_in,
   output logic      [31:0]       avs_readdata_out,
   output logic                   avs_waitrequest_out,
   input  wire logic              rx_valid_in,
   input  wire logic [7:0]        rx_byte_in,
   output logic                   tx_valid_out,
   output logic      [7:0]        tx_byte_out,
   input  wire logic              tx_ready_in,
   output logic                   data_valid_out,
   output logic      [7:0]        data_byte_out,
   output logic                   cmd_pending_out,
   output ccd_pkg::ccd_kind_t     cmd_kind_out,
   output logic      [23:0]       access_cond_out
);
   import ccd_pkg::*;

   if (RESP_DEPTH < 12 || RESP_DEPTH > 16 || CAP_DEPTH < 3 || CAP_DEPTH > 16) begin : g_bad
      $error("ccd_decoder buffer depths out of range");
   end

   ccd_state_t  st_q;
   ccd_kind_t   kind_q;
   ccd_kind_t   kind_w;
   logic [2:0]  hidx_q;
   logic [7:0]  cla_q, ins_q, p1_q, p2_q, p3_q, sw1_q, sw2_q, idx_q;
   logic [7:0]  rlen_q, reclen_q, tx_byte_q, dbyte_q, xlen_w, out_byte;
   logic        ravail_q, rinc_q, tx_valid_q, dvalid_q, ack_q;
   logic [23:0] acc_q;
   logic [31:0] rdata_q, rd_mux, wmask, wmerge_rec, wmerge_acc;
   logic [15:0] chk_w;
   logic [7:0]  resp_a, resp_b, cap_a, cap_b;
   logic        hdr_done, slot_free, wr_take, done_wr, done_ok, cap_wr, resp_wr;

   function automatic ccd_kind_t kind_of(input logic [7:0] ins);
      unique case (ins)
         INS_UPD_REC: return K_UPD;
         INS_SEEK:    return K_SEEK;
         INS_INC:     return K_INC;
         INS_VERIFY:  return K_VER;
         INS_CHANGE:  return K_CHG;
         INS_DISABLE: return K_DIS;
         INS_ENABLE:  return K_ENA;
         INS_UNBLOCK: return K_UNB;
         INS_INVAL:   return K_INV;
         INS_REHAB:   return K_REH;
         INS_AUTH:    return K_AUTH;
         INS_SLEEP:   return K_SLEEP;
         INS_GETRESP: return K_GETR;
         default:     return K_NONE;
      endcase
   endfunction

   // parameter check; zero means the header is acceptable
   function automatic logic [15:0] check(input ccd_kind_t k, input logic [7:0] p1,
                                         input logic [7:0] p2, input logic [7:0] p3,
                                         input logic [7:0] rl);
      logic       bad12;
      logic [7:0] want;
      bad12 = (p1 != BYTE_ZERO) || (p2 != BYTE_ZERO);
      want  = BYTE_ZERO;
      unique case (k)
         K_UPD: begin
            bad12 = p2 < MODE_NEXT || p2 > MODE_ABS; // RULE_01
            want  = p3;
         end
         K_SEEK: begin
            bad12 = (p1 != BYTE_ZERO) || p2[3:0] > SEEK_MODE_MAX || p2[7:4] > SEEK_TYPE2; // RULE_03 RULE_04
            want  = p3;
         end
         K_INC: want = LEN_ADDEND; // RULE_06
         K_VER, K_CHG: begin
            bad12 = (p1 != BYTE_ZERO) || (p2 != SECRET_1 && p2 != SECRET_2); // RULE_07
            want  = (k == K_VER) ? LEN_SECRET : LEN_TWO_SEC;
         end
         K_DIS, K_ENA: begin
            bad12 = (p1 != BYTE_ZERO) || (p2 != SECRET_1); // RULE_08
            want  = LEN_SECRET;
         end
         K_UNB: begin
            bad12 = (p1 != BYTE_ZERO) || (p2 != UNB_SECRET_1 && p2 != SECRET_2); // RULE_09
            want  = LEN_TWO_SEC;
         end
         K_AUTH: want = LEN_CHALL; // RULE_11
         K_GETR: want = (p3 > rl) ? rl : p3; // RULE_13
         default: want = BYTE_ZERO; // RULE_10 RULE_12
      endcase
      if (bad12) begin
         return {SW1_P12, BYTE_ZERO};
      end else if (p3 != want) begin
         return {SW1_P3, want};
      end
      return 16'h0000;
   endfunction

   assign kind_w    = kind_of(ins_q);
   assign hdr_done  = st_q == ST_HDR && rx_valid_in && hidx_q == HDR_LAST; // RULE_25
   assign chk_w     = check(kind_w, p1_q, p2_q, rx_byte_in, rlen_q);
   assign slot_free = !tx_valid_q || tx_ready_in;

   // response length after a successful command
   always_comb begin
      xlen_w = BYTE_ZERO;
      if (kind_q == K_AUTH) begin
         xlen_w = RESP_LEN_AUTH; // RULE_11
      end else if (kind_q == K_SEEK && p2_q[7:4] == SEEK_TYPE2) begin
         xlen_w = RESP_LEN_SEEK2; // RULE_05
      end else if (kind_q == K_INC) begin
         xlen_w = reclen_q + LEN_ADDEND; // RULE_06
      end
   end

   // bus slave: one wait cycle on every access
   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
   assign wr_take  = avs_write_in && ack_q;
   assign done_wr  = wr_take && avs_address_in == REG_CTRL && st_q == ST_EXEC;
   assign done_ok  = avs_writedata_in[DONE_OK_BIT];
   assign wmask    = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                      {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   assign wmerge_rec = ({24'h0, reclen_q} & ~wmask) | (avs_writedata_in & wmask);
   assign wmerge_acc = ({8'h00, acc_q} & ~wmask) | (avs_writedata_in & wmask);
   assign resp_wr  = wr_take && avs_address_in[7:6] == REGION_RESP && avs_byteenable_in[0];
   assign cap_wr   = st_q == ST_DIN && rx_valid_in && {24'h0, idx_q} < CAP_DEPTH;

   ccd_byte_buf #(.DEPTH(RESP_DEPTH)) u_resp (
      .clock_in     (clock_in),
      .wr_en_in     (resp_wr),
      .wr_addr_in   (avs_address_in[5:2]),
      .wr_data_in   (avs_writedata_in[7:0]),
      .rda_addr_in  (avs_address_in[5:2]),
      .rda_data_out (resp_a),
      .rdb_addr_in  (idx_q[3:0]),
      .rdb_data_out (resp_b)
   );

   ccd_byte_buf #(.DEPTH(CAP_DEPTH)) u_cap (
      .clock_in     (clock_in),
      .wr_en_in     (cap_wr),
      .wr_addr_in   (idx_q[3:0]),
      .wr_data_in   (rx_byte_in),
      .rda_addr_in  (avs_address_in[5:2]),
      .rda_data_out (cap_a),
      .rdb_addr_in  (4'(idx_q - reclen_q)),
      .rdb_data_out (cap_b)
   );

   // increase answer: record bytes, then the addend as it came in
   assign out_byte = (rinc_q && idx_q >= reclen_q) ? cap_b : resp_b; // RULE_06

   always_comb begin
      unique case (avs_address_in[7:6])
         REGION_RESP: rd_mux = {24'h0, resp_a};
         REGION_CAP:  rd_mux = {24'h0, cap_a};
         default: begin
            if (avs_address_in == REG_CTRL) begin
               rd_mux = {8'h00, rlen_q, 4'h0, kind_q, 6'h00, ravail_q, st_q == ST_EXEC};
            end else if (avs_address_in == REG_HEADER) begin
               rd_mux = {p3_q, p2_q, p1_q, ins_q};
            end else if (avs_address_in == REG_RECLEN) begin
               rd_mux = {24'h0, reclen_q};
            end else if (avs_address_in == REG_ACCESS) begin
               rd_mux = {8'h00, acc_q};
            end else begin
               rd_mux = 32'h0; // RULE_17
            end
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ack_q <= (avs_read_in || avs_write_in) && !ack_q;
         if (avs_read_in && !ack_q) begin
            rdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         reclen_q <= RECLEN_RST;
         acc_q    <= ACCESS_RST;
      end else if (wr_take && avs_address_in == REG_RECLEN) begin
         reclen_q <= wmerge_rec[7:0];
      end else if (wr_take && avs_address_in == REG_ACCESS) begin
         acc_q <= wmerge_acc[23:0]; // RULE_20 RULE_21
      end
   end

   // command sequencer
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         st_q   <= ST_HDR;
         kind_q <= K_NONE;
         hidx_q <= 3'h0;
         idx_q  <= 8'h00;
         cla_q  <= 8'h00;
         ins_q  <= 8'h00;
         p1_q   <= 8'h00;
         p2_q   <= 8'h00;
         p3_q   <= 8'h00;
         sw1_q  <= 8'h00;
         sw2_q  <= 8'h00;
      end else begin
         unique case (st_q)
            ST_HDR: if (rx_valid_in) begin
               hidx_q <= hidx_q + 3'h1;
               unique case (hidx_q)
                  3'h0: cla_q <= rx_byte_in;
                  3'h1: ins_q <= rx_byte_in;
                  3'h2: p1_q  <= rx_byte_in;
                  3'h3: p2_q  <= rx_byte_in;
                  default: ;
               endcase
               if (hdr_done) begin
                  hidx_q <= 3'h0;
                  idx_q  <= 8'h00;
                  p3_q   <= rx_byte_in;
                  kind_q <= kind_w;
                  if (kind_w == K_UPD && p2_q != MODE_ABS) begin
                     p1_q <= BYTE_ZERO; // RULE_02
                  end
                  st_q <= ST_SW1;
                  if (cla_q != CLA_CARD) begin
                     {sw1_q, sw2_q} <= {SW1_CLA, BYTE_ZERO}; // RULE_24
                  end else if (kind_w == K_NONE) begin
                     {sw1_q, sw2_q} <= {SW1_INS, BYTE_ZERO}; // RULE_24
                  end else if (kind_w == K_GETR && !ravail_q) begin
                     {sw1_q, sw2_q} <= {SW1_TECH, BYTE_ZERO}; // RULE_14 RULE_23
                  end else if (chk_w != 16'h0000) begin
                     {sw1_q, sw2_q} <= chk_w;
                  end else if (kind_w == K_GETR) begin
                     {sw1_q, sw2_q} <= {SW1_OK, BYTE_ZERO};
                     st_q <= ST_DOUT;
                  end else if (kind_w == K_SLEEP) begin
                     {sw1_q, sw2_q} <= {SW1_OK, BYTE_ZERO}; // RULE_12
                  end else if (rx_byte_in == BYTE_ZERO) begin
                     st_q <= ST_EXEC; // RULE_10
                  end else begin
                     st_q <= ST_DIN;
                  end
               end
            end
            ST_DIN: if (rx_valid_in) begin
               idx_q <= idx_q + 8'h01;
               if (idx_q == p3_q - 8'h01) begin
                  st_q <= ST_EXEC; // RULE_25
               end
            end
            ST_EXEC: if (done_wr) begin
               st_q <= ST_SW1;
               if (!done_ok) begin
                  {sw1_q, sw2_q} <= {avs_writedata_in[7:0], avs_writedata_in[15:8]};
               end else if (xlen_w != BYTE_ZERO) begin
                  {sw1_q, sw2_q} <= {SW1_RESP, xlen_w}; // RULE_22
               end else begin
                  {sw1_q, sw2_q} <= {SW1_OK, BYTE_ZERO}; // RULE_22
               end
            end
            ST_DOUT: if (idx_q == p3_q) begin
               st_q <= ST_SW1;
            end else if (slot_free) begin
               idx_q <= idx_q + 8'h01;
            end
            ST_SW1: if (slot_free) begin
               st_q <= ST_SW2;
            end
            ST_SW2: if (slot_free) begin
               st_q <= ST_HDR;
            end
            default: st_q <= ST_HDR;
         endcase
      end
   end

   // pending response: root directory data is armed from activation
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         ravail_q <= 1'b1; // RULE_15
         rlen_q   <= RESET_RESP_LEN;
         rinc_q   <= 1'b0;
      end else if (hdr_done && kind_w != K_GETR) begin
         ravail_q <= 1'b0; // RULE_14
      end else if (done_wr && done_ok && xlen_w != BYTE_ZERO) begin
         ravail_q <= 1'b1; // RULE_13
         rlen_q   <= xlen_w;
         rinc_q   <= kind_q == K_INC;
      end else if (st_q == ST_DOUT && idx_q == p3_q) begin
         ravail_q <= 1'b0;
      end
   end

   // outgoing bytes, b8 on bit 7
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         tx_valid_q <= 1'b0;
         tx_byte_q  <= 8'h00;
      end else if (slot_free) begin
         tx_valid_q <= (st_q == ST_DOUT && idx_q != p3_q) || st_q == ST_SW1 || st_q == ST_SW2;
         unique case (st_q)
            ST_DOUT: tx_byte_q <= out_byte; // RULE_16 RULE_11
            ST_SW1:  tx_byte_q <= sw1_q;
            ST_SW2:  tx_byte_q <= sw2_q;
            default: tx_byte_q <= tx_byte_q;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         dvalid_q <= 1'b0;
         dbyte_q  <= 8'h00;
      end else begin
         dvalid_q <= st_q == ST_DIN && rx_valid_in; // RULE_25
         dbyte_q  <= rx_byte_in;
      end
   end

   assign avs_readdata_out = rdata_q;
   assign tx_valid_out     = tx_valid_q;
   assign tx_byte_out      = tx_byte_q;
   assign data_valid_out   = dvalid_q;
   assign data_byte_out    = dbyte_q;
   assign cmd_pending_out  = st_q == ST_EXEC;
   assign cmd_kind_out     = kind_q;
   assign access_cond_out  = acc_q;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);

   property p_cla;
      hdr_done && cla_q != CLA_CARD |=> st_q == ST_SW1 && sw1_q == SW1_CLA && sw2_q == 8'h00;
   endproperty
   a_cla: assert property (p_cla) else $error("wrong class not refused"); // RULE_24

   property p_ins;
      hdr_done && cla_q == CLA_CARD && kind_w == K_NONE |=> sw1_q == SW1_INS;
   endproperty
   a_ins: assert property (p_ins) else $error("unknown instruction not refused"); // RULE_24

   property p_getr_late;
      hdr_done && cla_q == CLA_CARD && kind_w == K_GETR && !ravail_q
         |=> sw1_q == SW1_TECH && sw2_q == 8'h00 ##1 st_q == ST_SW2;
   endproperty
   a_getr_late: assert property (p_getr_late) else $error("late get-response served"); // RULE_14

   property p_clear;
      hdr_done && kind_w != K_GETR |=> !ravail_q;
   endproperty
   a_clear: assert property (p_clear) else $error("response kept after other command"); // RULE_13

   property p_upd_p1;
      hdr_done && kind_w == K_UPD && p2_q == MODE_NEXT |=> p1_q == 8'h00;
   endproperty
   a_upd_p1: assert property (p_upd_p1) else $error("p1 kept in relative mode"); // RULE_02

   property p_auth;
      done_wr && done_ok && kind_q == K_AUTH |=> sw1_q == SW1_RESP && sw2_q == 8'h0c && ravail_q;
   endproperty
   a_auth: assert property (p_auth) else $error("authentication length wrong"); // RULE_11

   property p_seek1;
      done_wr && done_ok && kind_q == K_SEEK && p2_q[7:4] == 4'h0 |=> sw1_q == SW1_OK;
   endproperty
   a_seek1: assert property (p_seek1) else $error("type 1 seek offered data"); // RULE_05

   property p_inc;
      done_wr && done_ok && kind_q == K_INC |=> sw2_q == $past(reclen_q) + 8'h03;
   endproperty
   a_inc: assert property (p_inc) else $error("increase length wrong"); // RULE_06

   property p_din;
      st_q == ST_DIN && rx_valid_in && idx_q == p3_q - 8'h01 |=> st_q == ST_EXEC ##1 !data_valid_out;
   endproperty
   a_din: assert property (p_din) else $error("data phase length wrong"); // RULE_25

   property p_sw;
      st_q == ST_SW1 && slot_free |=> tx_valid_out && tx_byte_out == $past(sw1_q);
   endproperty
   a_sw: assert property (p_sw) else $error("first status byte not sent"); // RULE_22

   c_auth: cover property (done_wr && done_ok && kind_q == K_AUTH);
   c_getr: cover property (st_q == ST_DOUT && idx_q == p3_q && p3_q != 8'h00);
   c_seek2: cover property (done_wr && kind_q == K_SEEK && p2_q[7:4] == SEEK_TYPE2);
endmodule // ccd_decoder
`default_nettype wire

/* design/ccd_pkg.sv */
// constants and types of the card command decoder
package ccd_pkg;
   localparam logic [7:0] CLA_CARD    = 8'ha0;
   localparam logic [7:0] INS_UPD_REC = 8'hdc;
   localparam logic [7:0] INS_SEEK    = 8'ha2;
   localparam logic [7:0] INS_INC     = 8'h32;
   localparam logic [7:0] INS_VERIFY  = 8'h20;
   localparam logic [7:0] INS_CHANGE  = 8'h24;
   localparam logic [7:0] INS_DISABLE = 8'h26;
   localparam logic [7:0] INS_ENABLE  = 8'h28;
   localparam logic [7:0] INS_UNBLOCK = 8'h2c;
   localparam logic [7:0] INS_INVAL   = 8'h04;
   localparam logic [7:0] INS_REHAB   = 8'h44;
   localparam logic [7:0] INS_AUTH    = 8'h88;
   localparam logic [7:0] INS_SLEEP   = 8'hfa;
   localparam logic [7:0] INS_GETRESP = 8'hc0;
   localparam logic [7:0] MODE_NEXT   = 8'h02;
   localparam logic [7:0] MODE_ABS    = 8'h04;
   localparam logic [7:0] SECRET_1    = 8'h01;
   localparam logic [7:0] SECRET_2    = 8'h02;
   localparam logic [7:0] UNB_SECRET_1 = 8'h00;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;
   localparam logic [7:0] LEN_ADDEND  = 8'h03;
   localparam logic [7:0] LEN_SECRET  = 8'h08;
   localparam logic [7:0] LEN_TWO_SEC = 8'h10;
   localparam logic [7:0] LEN_CHALL   = 8'h10;
   localparam logic [7:0] SW1_OK      = 8'h90;
   localparam logic [7:0] SW1_RESP    = 8'h9f;
   localparam logic [7:0] SW1_TECH    = 8'h6f;
   localparam logic [7:0] SW1_INS     = 8'h6d;
   localparam logic [7:0] SW1_CLA     = 8'h6e;
   localparam logic [7:0] SW1_P3      = 8'h67;
   localparam logic [7:0] SW1_P12     = 8'h6b;
   localparam logic [7:0] RESP_LEN_AUTH  = 8'h0c;
   localparam logic [7:0] RESP_LEN_SEEK2 = 8'h01;
   localparam logic [3:0] SEEK_MODE_MAX  = 4'h3;
   localparam logic [3:0] SEEK_TYPE2     = 4'h1;
   localparam logic [2:0] HDR_LAST       = 3'h4;
   localparam logic [7:0] RESET_RESP_LEN = 8'h16;
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_HEADER  = 8'h04;
   localparam logic [7:0] REG_RECLEN  = 8'h08;
   localparam logic [7:0] REG_ACCESS  = 8'h0c;
   localparam logic [1:0] REGION_RESP = 2'h1;
   localparam logic [1:0] REGION_CAP  = 2'h2;
   localparam int         DONE_OK_BIT = 16;
   localparam logic [7:0]  RECLEN_RST = 8'h00;
   localparam logic [23:0] ACCESS_RST = 24'h000000;
   localparam logic [3:0] AC_ALWAYS   = 4'h0;
   localparam logic [3:0] AC_SECRET1  = 4'h1;
   localparam logic [3:0] AC_SECRET2  = 4'h2;
   localparam logic [3:0] AC_RESERVED = 4'h3;
   localparam logic [3:0] AC_ADMIN_LO = 4'h4;

   typedef enum logic [2:0] {ST_HDR, ST_DIN, ST_EXEC, ST_DOUT, ST_SW1, ST_SW2} ccd_state_t;
   typedef enum logic [3:0] {K_UPD, K_SEEK, K_INC, K_VER, K_CHG, K_DIS, K_ENA, K_UNB,
                             K_INV, K_REH, K_AUTH, K_SLEEP, K_GETR, K_NONE} ccd_kind_t;
endpackage

/* design/ccd_byte_buf.sv */
// small byte store with one write and two read ports
`timescale 1ns/1ps
`default_nettype none
module ccd_byte_buf #(parameter int DEPTH = 16) (
   input  wire logic       clock_in,
   input  wire logic       wr_en_in,
   input  wire logic [3:0] wr_addr_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic [3:0] rda_addr_in,
   output logic      [7:0] rda_data_out,
   input  wire logic [3:0] rdb_addr_in,
   output logic      [7:0] rdb_data_out
);
   logic [7:0] mem [DEPTH];

   if (DEPTH < 1 || DEPTH > 16) begin : g_bad
      $error("ccd_byte_buf depth out of range");
   end

   always_ff @(posedge clock_in) begin
      if (wr_en_in && {28'h0, wr_addr_in} < DEPTH) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // beyond the depth reads as zero
   assign rda_data_out = ({28'h0, rda_addr_in} < DEPTH) ? mem[rda_addr_in] : 8'h00;
   assign rdb_data_out = ({28'h0, rdb_addr_in} < DEPTH) ? mem[rdb_addr_in] : 8'h00;
endmodule // ccd_byte_buf
`default_nettype wire

/* bench/ccd_term.sv */
// terminal model: sends headers and data, takes card bytes with stalls
`timescale 1ns/1ps
`default_nettype none
module ccd_term (
   input  wire logic       clock_in,
   output logic            rx_valid_out,
   output logic      [7:0] rx_byte_out,
   output logic            tx_ready_out
);
   initial begin
      rx_valid_out = 1'b0;
      rx_byte_out  = 8'h00;
      tx_ready_out = 1'b0;
   end
   // random stalls prove tx bytes are held until taken
   always @(posedge clock_in) tx_ready_out <= ($urandom % 4) != 0;
   task automatic send(input logic [7:0] b);
      @(posedge clock_in);
      rx_valid_out <= 1'b1;
      rx_byte_out  <= b;
      @(posedge clock_in);
      rx_valid_out <= 1'b0;
      rx_byte_out  <= ~b; // no stale value after release
   endtask
endmodule // ccd_term
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench of the card command decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ccd_pkg::*;
   logic        clock_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata, r, e;
   logic        wreq, rxv, txv, txr, dv, pend;
   logic [7:0]  rxb, txb, db, b;
   ccd_kind_t   kind;
   logic [23:0] acc;
   logic [7:0]  q[$], dq[$], dat[16];
   logic [7:0]  ov[12];
   int          num_errors = 0;
   int          compares = 0;
   always #4 clock_in = ~clock_in;
   ccd_decoder uut (.clock_in(clock_in), .resetn_in(resetn_in), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .rx_valid_in(rxv),
      .rx_byte_in(rxb), .tx_valid_out(txv), .tx_byte_out(txb), .tx_ready_in(txr),
      .data_valid_out(dv), .data_byte_out(db), .cmd_pending_out(pend),
      .cmd_kind_out(kind), .access_cond_out(acc));
   ccd_term term (.clock_in(clock_in), .rx_valid_out(rxv), .rx_byte_out(rxb),
      .tx_ready_out(txr));
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // oldest note meets each byte the card hands over
   always @(posedge clock_in) if (txv === 1'b1 && txr === 1'b1)
      chk(q.size() != 0 ? {24'h0, q.pop_front()} : 32'h100, {24'h0, txb});
   // every command data byte is echoed once, in order
   always @(posedge clock_in) if (dv === 1'b1)
      chk(dq.size() != 0 ? {24'h0, dq.pop_front()} : 32'h100, {24'h0, db});
   task automatic st(input logic [7:0] x, y);
      q.push_back(x);
      q.push_back(y);
   endtask
   // request held until the edge that sees waitrequest low; data taken there
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      adr <= a;
      wr  <= w;
      rd  <= !w;
      wd  <= d;
      do @(posedge clock_in); while (wreq !== 1'b0);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic cmd(input logic [7:0] c, i, p1, p2, p3, input int n);
      logic [7:0] h[5];
      h = '{c, i, p1, p2, p3};
      foreach (h[k]) term.send(h[k]);
      for (int k = 0; k < n; k++) begin
         dat[k] = 8'h30 + 8'($urandom % 10);
         dq.push_back(dat[k]);
         term.send(dat[k]);
      end
   endtask
   task automatic ok();
      int n;
      n = 0;
      while (pend !== 1'b1 && n < 100) begin
         @(posedge clock_in);
         n++;
      end
      chk(32'h1, {31'h0, pend});
      bus(1'b1, REG_CTRL, 32'h1 << DONE_OK_BIT);
   endtask
   task automatic drain();
      int n;
      n = 0;
      while (q.size() != 0 && n < 400) begin
         @(posedge clock_in);
         n++;
      end
      chk(32'h0, q.size() + dq.size());
      repeat (3) @(posedge clock_in);
   endtask
   task automatic give_verdict();
      $display("num_errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #100us;
      num_errors++;
      give_verdict();
   end
   initial begin
      r = $urandom(32'h9265e9a7);
      repeat (6) @(posedge clock_in);
      resetn_in <= 1'b1;
      for (int k = 0; k < 12; k++) begin
         ov[k] = 8'($urandom);
         bus(1'b1, 8'h40 + 8'(4 * k), {24'h0, ov[k]});
      end
      q = '{ov[0], ov[1], SW1_OK, 8'h00};
      cmd(CLA_CARD, INS_GETRESP, 8'h00, 8'h00, 8'h02, 0);
      drain();
      st(SW1_RESP, RESP_LEN_AUTH);
      cmd(CLA_CARD, INS_AUTH, 8'h00, 8'h00, LEN_CHALL, 16);
      ok();
      drain();
      foreach (ov[k]) q.push_back(ov[k]);
      st(SW1_OK, 8'h00);
      cmd(CLA_CARD, INS_GETRESP, 8'h00, 8'h00, RESP_LEN_AUTH, 0);
      drain();
      st(SW1_RESP, RESP_LEN_AUTH);
      cmd(CLA_CARD, INS_AUTH, 8'h00, 8'h00, LEN_CHALL, 16);
      ok();
      drain();
      st(SW1_OK, 8'h00);
      cmd(CLA_CARD, INS_INVAL, 8'h00, 8'h00, 8'h00, 0);
      ok();
      drain();
      st(SW1_TECH, 8'h00);
      cmd(CLA_CARD, INS_GETRESP, 8'h00, 8'h00, RESP_LEN_AUTH, 0);
      drain();
      st(SW1_OK, 8'h00);
      cmd(CLA_CARD, INS_VERIFY, 8'h00, SECRET_2, LEN_SECRET, 8);
      ok();
      drain();
      st(SW1_OK, 8'h00);
      cmd(CLA_CARD, INS_UNBLOCK, 8'h00, UNB_SECRET_1, LEN_TWO_SEC, 16);
      ok();
      drain();
      // stray record number must not reach software in next mode
      b = 8'($urandom) | 8'h01;
      cmd(CLA_CARD, INS_UPD_REC, b, MODE_NEXT, 8'h01, 1);
      bus(1'b0, REG_HEADER, 32'h0);
      chk({8'h01, MODE_NEXT, 8'h00, INS_UPD_REC}, r);
      chk(32'(K_UPD), 32'(kind));
      st(SW1_OK, 8'h00);
      ok();
      drain();
      e = {8'h00, 24'($urandom)};
      bus(1'b1, REG_ACCESS, e);
      bus(1'b0, REG_ACCESS, 32'h0);
      chk(e, r);
      chk(e, {8'h00, acc});
      bus(1'b1, REG_RECLEN, 32'h2);
      st(SW1_RESP, 8'h02 + LEN_ADDEND);
      cmd(CLA_CARD, INS_INC, 8'h00, 8'h00, LEN_ADDEND, 3);
      ok();
      drain();
      q = '{ov[0], ov[1], dat[0], dat[1], dat[2], SW1_OK, 8'h00};
      cmd(CLA_CARD, INS_GETRESP, 8'h00, 8'h00, 8'h05, 0);
      drain();
      st(SW1_RESP, RESP_LEN_SEEK2);
      cmd(CLA_CARD, INS_SEEK, 8'h00, 8'h12, 8'h01, 1);
      ok();
      drain();
      st(SW1_OK, 8'h00);
      cmd(CLA_CARD, INS_SEEK, 8'h00, 8'h03, 8'h01, 1);
      ok();
      drain();
      st(SW1_CLA, 8'h00);
      cmd(8'h00, INS_VERIFY, 8'h00, SECRET_1, LEN_SECRET, 0);
      drain();
      st(SW1_INS, 8'h00);
      cmd(CLA_CARD, 8'h12, 8'h00, 8'h00, 8'h00, 0);
      drain();
      st(SW1_OK, 8'h00);
      cmd(CLA_CARD, INS_SLEEP, 8'h00, 8'h00, 8'h00, 0);
      drain();
      bus(1'b0, 8'hfc, 32'h0);
      chk(32'h0, r);
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
